// File: hw/ctmc_pkg.sv
// constants and carrier types of the cluster test-mode control block
package ctmc_pkg;

	// ***********************************************************
	// bus geometry
	// ***********************************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// ***********************************************************
	// register byte offsets
	// ***********************************************************
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_LIVE = 12'h008;
	localparam logic [11:0] OFF_CORES = 12'h00c;

	// ***********************************************************
	// control register fields and reset value
	// ***********************************************************
	localparam int CTRL_W = 2;
	localparam int CTRL_HALT_BIT = 0;
	localparam int CTRL_CHECK_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;

	// ***********************************************************
	// fault status bit positions
	// ***********************************************************
	localparam int FAULT_W = 10;
	localparam int F_GATE = 0;
	localparam int F_RST = 1;
	localparam int F_RAM = 2;
	localparam int F_MCP = 3;
	localparam int F_CORE = 4;
	localparam int F_MUX = 5;
	localparam int F_SRC = 6;
	localparam int F_BYPASS = 7;
	localparam int F_REQ = 8;
	localparam int F_SRST = 9;
	localparam logic [9:0] STATUS_RESET = 10'h000;

	// ***********************************************************
	// widths and stage counts
	// ***********************************************************
	localparam int RST_W = 2;
	localparam int LIVE_W = 10;
	localparam int SYNC_STAGES = 2;
	localparam int MAX_LANES = 32;

	// ***********************************************************
	// carriers
	// ***********************************************************
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} ctmc_apb_req_t;

	typedef struct packed {
		logic gate_force_on;
		logic [1:0] reset_suppress;
		logic ram_select_hold;
		logic multicycle_hold;
		logic clock_mux_override;
		logic clock_source_choice;
		logic stretch_clock_bypass;
		logic selftest_request;
		logic selftest_reset_n;
	} ctmc_scan_t;

	typedef enum logic [1:0] {
		AP_IDLE = 2'b01,
		AP_DONE = 2'b10
	} ctmc_apb_st_t;

endpackage

// File: hw/ctmc_top.sv
// cluster test-mode control: scan overrides, self-test gating, check-copy compare, APB slave
`timescale 1ns/10ps
`default_nettype none

module ctmc_top #(
	parameter int CORES = 4,
	parameter int GATES = 8,
	parameter int RAMS = 8,
	parameter bit HAS_ANALYSER = 1'b1,
	parameter bit HAS_STRETCH = 1'b1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire ctmc_pkg::ctmc_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ctmc_pkg::ctmc_scan_t scan_ctrl,
	input wire ctmc_pkg::ctmc_scan_t scan_ctrl_dup,
	input wire logic [CORES-1:0] per_core_clock_off,
	input wire logic [CORES-1:0] per_core_clock_off_dup,
	input wire logic [GATES-1:0] func_gate_enable,
	input wire logic func_reset_n,
	input wire logic [RAMS-1:0] func_ram_select,
	input wire logic [CORES-1:0] func_core_clock_enable,
	input wire logic func_clock_select,
	input wire logic debug_halt_level,
	output logic [GATES-1:0] gate_enable,
	output logic [1:0] internal_reset_n,
	output logic [RAMS-1:0] ram_select,
	output logic multicycle_paths_enable,
	output logic [CORES-1:0] processor_core_clock_enable,
	output logic clock_mux_select,
	output logic stretch_bypass,
	output logic selftest_active,
	output logic selftest_path_reset_n,
	output logic analyser_halt_request,
	output logic test_control_fault
);
	import ctmc_pkg::*;

	// ***********************************************************
	// elaboration checks
	// ***********************************************************
	if (CORES < 1 || CORES > MAX_LANES) begin : g_chk_cores
		$error("CORES must be between 1 and 32");
	end
	if (GATES < 1 || GATES > MAX_LANES * 8) begin : g_chk_gates
		$error("GATES out of range");
	end
	if (RAMS < 1 || RAMS > MAX_LANES * 8) begin : g_chk_rams
		$error("RAMS out of range");
	end
	if (SYNC_STAGES < 2) begin : g_chk_sync
		$error("SYNC_STAGES must be at least 2");
	end
	if (RST_W != 2) begin : g_chk_rst
		$error("RST_W must match the reset port");
	end
	if (FAULT_W > DATA_W || CTRL_W > DATA_W) begin : g_chk_fields
		$error("register fields wider than the data bus");
	end
	if (LIVE_W != $bits(ctmc_scan_t)) begin : g_chk_live
		$error("LIVE_W must match the scan control carrier");
	end

	// ***********************************************************
	// helpers
	// ***********************************************************
	function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
		hit = (addr[11:2] == off[11:2]);
	endfunction

	function automatic logic differs(input logic [31:0] a, input logic [31:0] b);
		differs = |(a ^ b);
	endfunction

	// ***********************************************************
	// declarations
	// ***********************************************************
	ctmc_apb_st_t apb_st;
	logic [CTRL_W-1:0] ctrl;
	logic [FAULT_W-1:0] status;
	logic [FAULT_W-1:0] mismatch;
	logic [FAULT_W-1:0] next_status;
	logic [FAULT_W-1:0] clear_mask;
	logic [31:0] read_word;
	logic read_ok;
	logic wr_fire;
	logic take;
	ctmc_apb_st_t next_apb_st;
	logic [SYNC_STAGES-1:0] halt_sync;
	logic [1:0] rst_stage1;
	logic [1:0] rst_stage2;

	// ***********************************************************
	// apb slave, one wait state
	// ***********************************************************
	// transfer completes on the edge where pready is already high
	assign wr_fire = apb_req.psel && apb_req.penable && apb_req.pwrite && (apb_st == AP_DONE);
	assign take = apb_req.psel && apb_req.penable && (apb_st == AP_IDLE);

	always_comb begin
		read_word = 32'h0000_0000;
		read_ok = 1'b1;
		if (hit(apb_req.paddr, OFF_CTRL)) begin
			read_word = DATA_W'(ctrl);
		end else if (hit(apb_req.paddr, OFF_STATUS)) begin
			read_word = DATA_W'(status);
		end else if (hit(apb_req.paddr, OFF_LIVE)) begin
			read_word = DATA_W'(scan_ctrl);
		end else if (hit(apb_req.paddr, OFF_CORES)) begin
			read_word = DATA_W'(per_core_clock_off);
		end else begin
			read_ok = 1'b0;
		end
	end

	always_comb begin
		next_apb_st = apb_st;
		case (apb_st)
			AP_IDLE: begin
				if (take) begin
					next_apb_st = AP_DONE;
				end
			end
			AP_DONE: begin
				next_apb_st = AP_IDLE;
			end
			default: begin
				next_apb_st = AP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			apb_st <= AP_IDLE;
		end else if (clk_en) begin
			apb_st <= next_apb_st;
		end
	end

	// ready stands for one cycle after the access edge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pready <= 1'b0;
		end else if (clk_en) begin
			pready <= take;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pslverr <= take & ~read_ok;
		end
	end

	// writes answer with zero data
	always_ff @(posedge clk) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
		end else if (clk_en) begin
			prdata <= (take && !apb_req.pwrite) ? read_word : 32'h0000_0000;
		end
	end

	// ***********************************************************
	// control register
	// ***********************************************************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl <= CTRL_RESET;
		end else if (clk_en) begin
			if (wr_fire && hit(apb_req.paddr, OFF_CTRL)) begin
				ctrl <= apb_req.pwdata[CTRL_W-1:0];
			end
		end
	end

	// ***********************************************************
	// check-copy compare and sticky fault status
	// ***********************************************************
	// compare each control with its copy
	always_comb begin
		mismatch = '0;
		mismatch[F_GATE] = scan_ctrl.gate_force_on ^ scan_ctrl_dup.gate_force_on;
		mismatch[F_RST] = differs(32'(scan_ctrl.reset_suppress), 32'(scan_ctrl_dup.reset_suppress));
		mismatch[F_RAM] = scan_ctrl.ram_select_hold ^ scan_ctrl_dup.ram_select_hold;
		mismatch[F_MCP] = scan_ctrl.multicycle_hold ^ scan_ctrl_dup.multicycle_hold;
		mismatch[F_CORE] = differs(32'(per_core_clock_off), 32'(per_core_clock_off_dup));
		mismatch[F_MUX] = scan_ctrl.clock_mux_override ^ scan_ctrl_dup.clock_mux_override;
		mismatch[F_SRC] = scan_ctrl.clock_source_choice ^ scan_ctrl_dup.clock_source_choice;
		mismatch[F_BYPASS] = scan_ctrl.stretch_clock_bypass ^ scan_ctrl_dup.stretch_clock_bypass;
		mismatch[F_REQ] = scan_ctrl.selftest_request ^ scan_ctrl_dup.selftest_request;
		mismatch[F_SRST] = scan_ctrl.selftest_reset_n ^ scan_ctrl_dup.selftest_reset_n;
	end

	// sticky flags, a new mismatch beats the clear while the check bit is set
	always_comb begin
		clear_mask = '0;
		if (wr_fire && hit(apb_req.paddr, OFF_STATUS)) begin
			clear_mask = apb_req.pwdata[FAULT_W-1:0];
		end
		next_status = status & ~clear_mask;
		if (ctrl[CTRL_CHECK_BIT]) begin
			next_status = next_status | mismatch;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			status <= STATUS_RESET;
			test_control_fault <= 1'b0;
		end else if (clk_en) begin
			status <= next_status;
			test_control_fault <= |next_status;
		end
	end

	// ***********************************************************
	// clock gates, clock mux, per-core clocks
	// ***********************************************************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			gate_enable <= '0;
		end else if (clk_en) begin
			gate_enable <= func_gate_enable | {GATES{scan_ctrl.gate_force_on}};
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			processor_core_clock_enable <= '0;
		end else if (clk_en) begin
			// disable bit stops the core clock
			processor_core_clock_enable <= func_core_clock_enable & ~per_core_clock_off;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			clock_mux_select <= 1'b0;
		end else if (clk_en) begin
			if (scan_ctrl.clock_mux_override) begin
				clock_mux_select <= scan_ctrl.clock_source_choice;
			end else begin
				clock_mux_select <= func_clock_select;
			end
		end
	end

	// ***********************************************************
	// internal resets
	// ***********************************************************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rst_stage1 <= 2'h0;
			rst_stage2 <= 2'h0;
			internal_reset_n <= 2'h0;
		end else if (clk_en) begin
			rst_stage1 <= {RST_W{func_reset_n}};
			rst_stage2 <= rst_stage1;
			// suppressed domains stay out of reset
			internal_reset_n <= rst_stage2 | scan_ctrl.reset_suppress;
		end
	end

	// ***********************************************************
	// ram controls
	// ***********************************************************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ram_select <= '0;
			multicycle_paths_enable <= 1'b0;
			stretch_bypass <= 1'b0;
		end else if (clk_en) begin
			ram_select <= scan_ctrl.ram_select_hold ? '0 : func_ram_select;
			multicycle_paths_enable <= ~scan_ctrl.multicycle_hold;
			// bypass only when the option is built
			stretch_bypass <= HAS_STRETCH & scan_ctrl.stretch_clock_bypass;
		end
	end

	// ***********************************************************
	// memory self-test
	// ***********************************************************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			selftest_active <= 1'b0;
			selftest_path_reset_n <= 1'b0;
		end else if (clk_en) begin
			selftest_active <= scan_ctrl.selftest_request;
			selftest_path_reset_n <= scan_ctrl.selftest_reset_n;
		end
	end

	// ***********************************************************
	// analyser halt request
	// ***********************************************************
	// two-stage capture of the debug-domain level
	always_ff @(posedge clk) begin
		if (!resetn) begin
			halt_sync <= '0;
		end else if (clk_en) begin
			halt_sync <= {halt_sync[SYNC_STAGES-2:0], debug_halt_level};
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			analyser_halt_request <= 1'b0;
		end else if (clk_en) begin
			// stays low without the analyser option
			analyser_halt_request <= HAS_ANALYSER
				& (halt_sync[SYNC_STAGES-1] | ctrl[CTRL_HALT_BIT]);
		end
	end

endmodule

`default_nettype wire

// File: tb/ctmc_scan_model.sv
// scan tester and self-test controller model driving test controls and check copies
`timescale 1ns/10ps
`default_nettype none
module ctmc_scan_model #(
	parameter int CORES = 4
) (
	input wire logic clk,
	input wire ctmc_pkg::ctmc_scan_t want,
	input wire logic [CORES-1:0] want_cores,
	input wire logic corrupt,
	input wire logic halt_request,
	output ctmc_pkg::ctmc_scan_t scan_ctrl,
	output ctmc_pkg::ctmc_scan_t scan_ctrl_dup,
	output logic [CORES-1:0] cores_off,
	output logic [CORES-1:0] cores_off_dup,
	output logic halt_seen
);
	import ctmc_pkg::*;
	logic [1:0] halt_sync;
	// controls and copies, inverted copy only on command
	always_ff @(posedge clk) begin
		scan_ctrl <= want;
		scan_ctrl_dup <= corrupt ? ~want : want;
		cores_off <= want_cores;
		cores_off_dup <= corrupt ? ~want_cores : want_cores;
	end
	always_ff @(posedge clk) begin
		halt_sync <= {halt_sync[0], halt_request};
	end
	assign halt_seen = halt_sync[1];
endmodule
`default_nettype wire

// File: tb/ctmc_checker.sv
// concurrent checks on the ports of the test-mode control block
`timescale 1ns/10ps
`default_nettype none
module ctmc_checker #(
	parameter int CORES = 4,
	parameter int GATES = 8,
	parameter int RAMS = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire ctmc_pkg::ctmc_scan_t scan_ctrl,
	input wire ctmc_pkg::ctmc_scan_t scan_ctrl_dup,
	input wire logic [CORES-1:0] per_core_clock_off,
	input wire logic debug_halt_level,
	input wire logic [GATES-1:0] gate_enable,
	input wire logic [1:0] internal_reset_n,
	input wire logic [RAMS-1:0] ram_select,
	input wire logic multicycle_paths_enable,
	input wire logic [CORES-1:0] processor_core_clock_enable,
	input wire logic clock_mux_select,
	input wire logic stretch_bypass,
	input wire logic selftest_active,
	input wire logic selftest_path_reset_n,
	input wire logic analyser_halt_request,
	input wire logic test_control_fault
);
	import ctmc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	gate_force_a: assert property (clk_en && scan_ctrl.gate_force_on |=> &gate_enable)
		else $error("gates not forced");
	reset_hold_a: assert property (clk_en && scan_ctrl.reset_suppress[0] |=>
		internal_reset_n[0])
		else $error("reset not suppressed");
	ram_hold_a: assert property (clk_en && scan_ctrl.ram_select_hold |=>
		ram_select == '0)
		else $error("ram select active");
	mcp_hold_a: assert property (clk_en && scan_ctrl.multicycle_hold |=>
		!multicycle_paths_enable)
		else $error("multicycle on");
	core_off_a: assert property (resetn && clk_en |=>
		(processor_core_clock_enable & $past(per_core_clock_off)) == '0)
		else $error("core clock runs");
	mux_force_a: assert property (resetn && clk_en && scan_ctrl.clock_mux_override |=>
		clock_mux_select == $past(scan_ctrl.clock_source_choice))
		else $error("mux not forced");
	stretch_skip_a: assert property (clk_en && scan_ctrl.stretch_clock_bypass |=>
		stretch_bypass)
		else $error("bypass missing");
	selftest_pass_a: assert property (resetn && clk_en |=>
		selftest_active == $past(scan_ctrl.selftest_request)
		&& selftest_path_reset_n == $past(scan_ctrl.selftest_reset_n))
		else $error("selftest wrong");
	copy_fault_a: assert property (clk_en && scan_ctrl != scan_ctrl_dup |=>
		test_control_fault)
		else $error("fault missed");
	halt_sync_a: assert property ((clk_en && debug_halt_level) [*3] |=>
		analyser_halt_request)
		else $error("halt late");
endmodule
`default_nettype wire

// File: tb/test_cluster_test_mode_control.sv
// self-checking bench for the cluster test-mode control block
`timescale 1ns/10ps
`default_nettype none
module test_cluster_test_mode_control;
	import ctmc_pkg::*;
	logic clk, resetn, clk_en, func_reset_n, debug_halt_level, corrupt, halt_seen, pready, pslverr;
	logic err, mcp_en, mux_sel, bypass, st_act, st_rst, halt, fault;
	ctmc_apb_req_t apb_req;
	ctmc_scan_t w, sc, sc_dup;
	logic [3:0] cores, c_off, c_dup, core_en;
	logic [31:0] prdata, rd;
	logic [7:0] gate_en, ram_sel;
	logic [1:0] int_rst;
	int fails, n_tests;
	ctmc_top ctmc_top_i (.clk(clk), .resetn(resetn), .clk_en(clk_en), .apb_req(apb_req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scan_ctrl(sc),
		.scan_ctrl_dup(sc_dup), .per_core_clock_off(c_off), .per_core_clock_off_dup(c_dup),
		.func_gate_enable(8'h00), .func_reset_n(func_reset_n), .func_ram_select(8'hff),
		.func_core_clock_enable(4'hf), .func_clock_select(1'b1),
		.debug_halt_level(debug_halt_level), .gate_enable(gate_en), .internal_reset_n(int_rst),
		.ram_select(ram_sel), .multicycle_paths_enable(mcp_en),
		.processor_core_clock_enable(core_en), .clock_mux_select(mux_sel),
		.stretch_bypass(bypass), .selftest_active(st_act), .selftest_path_reset_n(st_rst),
		.analyser_halt_request(halt), .test_control_fault(fault));
	ctmc_scan_model ctmc_scan_model_i (.clk(clk), .want(w), .want_cores(cores),
		.corrupt(corrupt), .halt_request(halt), .scan_ctrl(sc), .scan_ctrl_dup(sc_dup),
		.cores_off(c_off), .cores_off_dup(c_dup), .halt_seen(halt_seen));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		i = 0;
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		err = pslverr;
		apb_req <= '0;
		if (pready !== 1'b1) begin
			fails++;
			close_out();
		end else begin
			@(posedge clk);
		end
	endtask
	task automatic s_regs();
		apb(1'b0, OFF_CTRL, 32'h0);
		check("ctrl", rd, 32'(CTRL_RESET));
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped", 32'(err), 32'h1);
		apb(1'b1, OFF_CTRL, 32'h3);
		repeat (2) @(posedge clk);
		check("sw halt", 32'(halt), 32'h1);
		apb(1'b1, OFF_CTRL, 32'h2);
	endtask
	task automatic s_scan();
		logic [9:0] v;
		func_reset_n <= 1'b0;
		repeat (5) @(posedge clk);
		for (int i = 0; i < 12; i++) begin
			v = i < 10 ? 10'h1 << i : (i == 10 ? 10'h3ff : 10'h018);
			w <= ctmc_scan_t'(v);
			cores <= i[3:0];
			repeat (3) @(posedge clk);
			check("outs", 32'({gate_en, ram_sel, core_en, int_rst, mcp_en, mux_sel, bypass,
				st_act, st_rst, fault}), 32'({{8{v[9]}}, {8{!v[6]}}, ~i[3:0], v[8:7],
				!v[5], (v[4] ? v[3] : 1'b1), v[2], v[1], v[0], 1'b0}));
			apb(1'b0, OFF_LIVE, 32'h0);
			check("live", rd, 32'(v));
		end
	endtask
	task automatic s_fault();
		corrupt <= 1'b1;
		@(posedge clk);
		corrupt <= 1'b0;
		repeat (3) @(posedge clk);
		check("fault", 32'(fault), 32'h1);
		apb(1'b0, OFF_STATUS, 32'h0);
		check("status", rd, 32'h3ff);
		apb(1'b1, OFF_STATUS, 32'h3ff);
		apb(1'b0, OFF_STATUS, 32'h0);
		check("cleared", rd, 32'h0);
		check("fault off", 32'(fault), 32'h0);
	endtask
	task automatic s_halt();
		debug_halt_level <= 1'b1;
		repeat (4) @(posedge clk);
		check("halt", 32'(halt), 32'h1);
		repeat (2) @(posedge clk);
		check("halt seen", 32'(halt_seen), 32'h1);
		debug_halt_level <= 1'b0;
		repeat (4) @(posedge clk);
		check("halt off", 32'(halt), 32'h0);
	endtask
	task automatic s_freeze();
		clk_en <= 1'b0;
		w <= ctmc_scan_t'(10'h200);
		cores <= 4'hf;
		repeat (4) @(posedge clk);
		check("frozen gates", 32'(gate_en), 32'h0);
		check("frozen cores", 32'(core_en), 32'h4);
		clk_en <= 1'b1;
		repeat (2) @(posedge clk);
		check("thawed gates", 32'(gate_en), 32'hff);
		check("thawed cores", 32'(core_en), 32'h0);
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		func_reset_n = 1'b1;
		debug_halt_level = 1'b0;
		corrupt = 1'b0;
		apb_req = '0;
		w = ctmc_scan_t'(10'h001);
		cores = 4'h0;
		fails = 0;
		n_tests = 0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		s_regs();
		s_scan();
		s_fault();
		s_halt();
		s_freeze();
		close_out();
	end
endmodule
bind ctmc_top ctmc_checker #(.CORES(CORES), .GATES(GATES), .RAMS(RAMS)) ctmc_checker_i (.*);
`default_nettype wire
